// ---- pmt_period_match_timer8.sv ----
/*
  The 8-bit period match timer with its Avalon-MM register slave, its
  prescaler and postscaler, the period interrupt and the time-base
  outputs toward the serial port and the PWM unit.
  Assumes one clock, mclk, with reset asynchronous and active high, and a
  master that holds each request until it sees waitrequest low.
*/
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module pmt_period_match_timer8
  import pmt_pkg::*;
#(
  parameter int QDIV = pmt_pkg::QUARTER_DIV
) (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic [pmt_pkg::ADDR_W-1:0] address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [pmt_pkg::DATA_W-1:0] writedata,
  input  wire logic [3:0]                byteenable,
  output var  logic [pmt_pkg::DATA_W-1:0] readdata,
  output logic                           waitrequest,
  output logic                           irq,
  output var  logic                      sspMatchPulse,
  output var  logic [pmt_pkg::REG_W-1:0]  pwmCount,
  output var  logic                      pwmMatchPulse
);

  // Width of the quarter-rate phase counter.
  localparam int QW = (QDIV > 1) ? $clog2(QDIV) : 1;
  localparam logic [QW-1:0] QLAST = QW'(QDIV - 1);

  // Maps the prescale code onto its terminal count.
  function automatic logic [3:0] pre_term(input logic [1:0] sel);
    logic [3:0] t;
    t = PRE_TERM_16;
    if (sel == 2'b00) begin
      t = PRE_TERM_1;
    end else if (sel == 2'b01) begin
      t = PRE_TERM_4;
    end
    return t;
  endfunction : pre_term

  // Register state.
  logic [REG_W-1:0]  counterFf;
  logic [REG_W-1:0]  limitFf;
  logic [6:0]        controlFf;
  logic              flagFf;
  logic              enableFf;
  logic [3:0]        preCntFf;
  logic [3:0]        postCntFf;
  logic [QW-1:0]     phaseFf;
  logic              ackFf;
  logic [DATA_W-1:0] readdataFf;
  logic              matchFf;

  // Next values.
  logic [REG_W-1:0]  nxt_counter;
  logic [3:0]        nxt_preCnt;
  logic [3:0]        nxt_postCnt;
  logic              nxt_flag;

  // Bus decode.
  wire logic [7:0] regIdx   = address[ADDR_W-1:2];
  wire logic       accept   = ackFf & (read | write);
  wire logic       wrLane   = write & ackFf & byteenable[0];
  wire logic [7:0] wrByte   = writedata[7:0];
  wire logic       wrFlags  = wrLane & (regIdx == IDX_IRQ_FLAGS);
  wire logic       wrCount  = wrLane & (regIdx == IDX_COUNTER);
  wire logic       wrCtrl   = wrLane & (regIdx == IDX_CONTROL);
  wire logic       wrEnab   = wrLane & (regIdx == IDX_IRQ_ENABLES);
  wire logic       wrLimit  = wrLane & (regIdx == IDX_LIMIT);

  // Control fields.
  wire logic [1:0] preSel   = controlFf[CTL_PRE_HI:CTL_PRE_LO];
  wire logic       counterOn = controlFf[CTL_ON];
  wire logic [3:0] postSel  = controlFf[CTL_POST_HI:CTL_POST_LO];

  // Time-base ticks; a control write swallows the tick of its cycle.
  wire logic quarterTick = (phaseFf == QLAST);
  wire logic preDone     = (preCntFf == pre_term(preSel));
  wire logic stepEn      = quarterTick & counterOn & ~wrCtrl;
  wire logic incTick     = stepEn & preDone;
  wire logic matchNow    = incTick & (counterFf == limitFf);
  wire logic postDone    = (postCntFf == postSel);
  wire logic flagEvent   = matchNow & postDone;

  // Read multiplexer; unmapped indices and upper bits read zero.
  wire logic [7:0] rdByte =
    (regIdx == IDX_IRQ_FLAGS)   ? 8'({flagFf, 1'b0}) :
    (regIdx == IDX_COUNTER)     ? counterFf :
    (regIdx == IDX_CONTROL)     ? {1'b0, controlFf} :
    (regIdx == IDX_IRQ_ENABLES) ? 8'({enableFf, 1'b0}) :
    (regIdx == IDX_LIMIT)       ? limitFf :
    8'h00;

  // Every access waits exactly one cycle before it is answered.
  assign waitrequest = (read | write) & ~ackFf;
  assign readdata    = readdataFf;

  // One level line for the unmasked period flag.
  assign irq = flagFf & enableFf;

  // Counter next value; a software write beats a coincident step.
  always_comb begin
    nxt_counter = counterFf;
    if (wrCount) begin
      nxt_counter = wrByte;
    end else if (matchNow) begin
      nxt_counter = RST_COUNTER;
    end else if (incTick) begin
      nxt_counter = REG_W'(counterFf + 8'h01);
    end
  end

  // Prescaler next value; it only runs while the timer is on.
  always_comb begin
    nxt_preCnt = preCntFf;
    if (wrCount | wrCtrl) begin
      nxt_preCnt = 4'h0;
    end else if (stepEn) begin
      nxt_preCnt = preDone ? 4'h0 : 4'(preCntFf + 4'h1);
    end
  end

  // Postscaler next value, advanced once per period match.
  always_comb begin
    nxt_postCnt = postCntFf;
    if (wrCount | wrCtrl) begin
      nxt_postCnt = 4'h0;
    end else if (matchNow) begin
      nxt_postCnt = postDone ? 4'h0 : 4'(postCntFf + 4'h1);
    end
  end

  // A hardware set wins over a write-one clear in the same cycle.
  always_comb begin
    nxt_flag = flagFf;
    if (wrFlags & wrByte[IRQ_PERIOD_BIT]) begin
      nxt_flag = 1'b0;
    end
    if (flagEvent) begin
      nxt_flag = 1'b1;
    end
  end

  // Bus handshake and registered read data.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ackFf      <= 1'b0;
      readdataFf <= '0;
    end else begin
      ackFf      <= waitrequest;
      readdataFf <= (read & ~ackFf) ? DATA_W'(rdByte) : readdataFf;
    end
  end

  // Software-owned configuration.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      limitFf   <= RST_LIMIT;
      controlFf <= RST_CONTROL;
      enableFf  <= 1'b0;
    end else begin
      if (wrLimit) begin
        limitFf <= wrByte;
      end
      if (wrCtrl) begin
        controlFf <= wrByte[CTL_POST_HI:CTL_PRE_LO];
      end
      if (wrEnab) begin
        enableFf <= wrByte[IRQ_PERIOD_BIT];
      end
    end
  end

  // Quarter-rate phase runs free so the instruction clock never pauses.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      phaseFf <= '0;
    end else begin
      phaseFf <= quarterTick ? '0 : QW'(phaseFf + 1'b1);
    end
  end

  // Counter, scalers and flag.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      counterFf <= RST_COUNTER;
      preCntFf  <= 4'h0;
      postCntFf <= 4'h0;
      flagFf    <= 1'b0;
      matchFf   <= 1'b0;
    end else begin
      counterFf <= nxt_counter;
      preCntFf  <= nxt_preCnt;
      postCntFf <= nxt_postCnt;
      flagFf    <= nxt_flag;
      matchFf   <= matchNow;
    end
  end

  // Time base for the serial port and the PWM unit, both registered.
  assign sspMatchPulse = matchFf;
  assign pwmMatchPulse = matchFf;
  assign pwmCount      = counterFf;

  // Checks on the timer behaviour.
  property p_wrapZero;
    @(posedge mclk) disable iff (reset)
      (matchNow && !wrCount) |=> (counterFf == 8'h00);
  endproperty
  a_wrapZero: assert property (p_wrapZero)
    else $error("Counter did not wrap to zero on match.");

  property p_advance;
    @(posedge mclk) disable iff (reset)
      (incTick && !matchNow && !wrCount)
        |=> (counterFf == 8'($past(counterFf) + 8'h01));
  endproperty
  a_advance: assert property (p_advance)
    else $error("Counter did not advance by one.");

  property p_stopped;
    @(posedge mclk) disable iff (reset)
      (!counterOn && !wrCount) |=> $stable(counterFf);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("Counter moved while the timer was off.");

  property p_ctrlKeeps;
    @(posedge mclk) disable iff (reset)
      (wrCtrl && !wrCount) |=> (counterFf == $past(counterFf));
  endproperty
  a_ctrlKeeps: assert property (p_ctrlKeeps)
    else $error("Control write changed the counter.");

  property p_clearScalers;
    @(posedge mclk) disable iff (reset)
      (wrCtrl || wrCount) |=> (preCntFf == 4'h0 && postCntFf == 4'h0);
  endproperty
  a_clearScalers: assert property (p_clearScalers)
    else $error("Scalers not cleared by a counter or control write.");

  property p_flagSet;
    @(posedge mclk) disable iff (reset)
      (matchNow && postCntFf == postSel) |=> flagFf;
  endproperty
  a_flagSet: assert property (p_flagSet)
    else $error("Period flag not set at postscaler terminal count.");

  property p_postStep;
    @(posedge mclk) disable iff (reset)
      (matchNow && !postDone && !wrCount)
        |=> (postCntFf == 4'($past(postCntFf) + 4'h1));
  endproperty
  a_postStep: assert property (p_postStep)
    else $error("Postscaler did not count the match.");

  property p_quarter;
    @(posedge mclk) disable iff (reset)
      quarterTick |=> (phaseFf == '0);
  endproperty
  a_quarter: assert property (p_quarter)
    else $error("Phase did not restart after the instruction tick.");

  property p_phaseStep;
    @(posedge mclk) disable iff (reset)
      !quarterTick |=> (phaseFf == QW'($past(phaseFf) + 1'b1));
  endproperty
  a_phaseStep: assert property (p_phaseStep)
    else $error("Phase did not advance between instruction ticks.");

  property p_sspPulse;
    @(posedge mclk) disable iff (reset)
      (matchNow && !wrCount) |=> (sspMatchPulse && counterFf == 8'h00)
        ##1 !sspMatchPulse;
  endproperty
  a_sspPulse: assert property (p_sspPulse)
    else $error("Serial port match pulse wrong.");

  property p_irqLine;
    @(posedge mclk) disable iff (reset)
      irq == (flagFf && enableFf);
  endproperty
  a_irqLine: assert property (p_irqLine)
    else $error("Interrupt line disagrees with flag and enable.");

  property p_bit7Zero;
    @(posedge mclk) disable iff (reset)
      (accept && read && regIdx == IDX_CONTROL) |-> !readdata[7];
  endproperty
  a_bit7Zero: assert property (p_bit7Zero)
    else $error("Control bit 7 read as one.");

  // Checks on the register bus, the scalers and the interrupt.
  property p_oneWait;
    @(posedge mclk) disable iff (reset)
      waitrequest |=> !waitrequest;
  endproperty
  a_oneWait: assert property (p_oneWait)
    else $error("Waitrequest stood for more than one cycle.");

  property p_limitWrite;
    @(posedge mclk) disable iff (reset)
      wrLimit |=> (limitFf == $past(wrByte));
  endproperty
  a_limitWrite: assert property (p_limitWrite)
    else $error("Period limit did not take the written value.");

  property p_counterWrite;
    @(posedge mclk) disable iff (reset)
      wrCount |=> (counterFf == $past(wrByte));
  endproperty
  a_counterWrite: assert property (p_counterWrite)
    else $error("Counter did not take the written value.");

  property p_countRead;
    @(posedge mclk) disable iff (reset)
      (read && !ackFf && regIdx == IDX_COUNTER)
        |=> (readdata == DATA_W'($past(counterFf)));
  endproperty
  a_countRead: assert property (p_countRead)
    else $error("Counter read returned a wrong value.");

  property p_preStep;
    @(posedge mclk) disable iff (reset)
      (stepEn && !preDone && !wrCount)
        |=> (preCntFf == 4'($past(preCntFf) + 4'h1));
  endproperty
  a_preStep: assert property (p_preStep)
    else $error("Prescaler did not count the instruction tick.");

  property p_preOne;
    @(posedge mclk) disable iff (reset)
      (preSel != 2'b00) || (preCntFf == 4'h0);
  endproperty
  a_preOne: assert property (p_preOne)
    else $error("Prescaler moved while dividing by one.");

  property p_preFour;
    @(posedge mclk) disable iff (reset)
      (preSel != 2'b01) || (preCntFf <= PRE_TERM_4);
  endproperty
  a_preFour: assert property (p_preFour)
    else $error("Prescaler passed its divide-by-four end.");

  property p_flagSticky;
    @(posedge mclk) disable iff (reset)
      (flagFf && !(wrFlags && wrByte[IRQ_PERIOD_BIT])) |=> flagFf;
  endproperty
  a_flagSticky: assert property (p_flagSticky)
    else $error("Period flag dropped without a clear.");

  property p_flagClear;
    @(posedge mclk) disable iff (reset)
      (wrFlags && wrByte[IRQ_PERIOD_BIT] && !flagEvent) |=> !flagFf;
  endproperty
  a_flagClear: assert property (p_flagClear)
    else $error("Writing one did not clear the period flag.");

  property p_noEarlyFlag;
    @(posedge mclk) disable iff (reset)
      (matchNow && !postDone && !flagFf) |=> !flagFf;
  endproperty
  a_noEarlyFlag: assert property (p_noEarlyFlag)
    else $error("Period flag set before the postscaler end.");

  property p_enableWrite;
    @(posedge mclk) disable iff (reset)
      wrEnab |=> (enableFf == $past(wrByte[IRQ_PERIOD_BIT]));
  endproperty
  a_enableWrite: assert property (p_enableWrite)
    else $error("Period enable did not take the written value.");

  property p_irqRises;
    @(posedge mclk) disable iff (reset)
      (wrEnab && wrByte[IRQ_PERIOD_BIT] && flagFf) |=> irq;
  endproperty
  a_irqRises: assert property (p_irqRises)
    else $error("Interrupt did not rise when a set flag was unmasked.");

endmodule : pmt_period_match_timer8

`default_nettype wire

// ---- pmt_pkg.sv ----
/*
  Constants for the 8-bit period match timer: register indices, field
  positions, reset values and scaler codes.
  Assumes a 32-bit Avalon-MM slave that places each 8-bit register in
  the low byte of one aligned word, at byte address four times its index.
*/
// What this block does
// - Counter counts up from zero and returns to zero after matching the limit.
// - Period limit is software read/write and resets to all ones.
// - Counter value is software read/write and resets to zero.
// - Counter clock is quarter-rate clock through a 1, 4 or 16 prescaler.
// - Each match feeds a 4-bit postscaler dividing by one to sixteen.
// - Postscaler terminal count sets the period flag at flag bit 1.
// - Counter or control writes, and reset, clear both scaler counters.
// - A control write leaves the counter value unchanged.
// - Counter stops while the on bit is clear, resumes when set.
// - Control holds postscale 6:3, on 2, prescale 1:0; bit 7 reads zero.
// - Match pulse before the postscaler goes out to the serial port.
// - Counter and match are offered to the PWM unit as time base.
// - Enable register holds the period enable at bit 1; resets zero.
`default_nettype none

package pmt_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0c;
  localparam logic [7:0] IDX_COUNTER     = 8'h11;
  localparam logic [7:0] IDX_CONTROL     = 8'h12;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_LIMIT       = 8'h92;

  // Bus geometry.
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;

  // Reset values.
  localparam logic [7:0] RST_LIMIT   = 8'hff;
  localparam logic [7:0] RST_COUNTER = 8'h00;
  localparam logic [6:0] RST_CONTROL = 7'h00;

  // Control field positions.
  localparam int CTL_PRE_LO  = 0;
  localparam int CTL_PRE_HI  = 1;
  localparam int CTL_ON      = 2;
  localparam int CTL_POST_LO = 3;
  localparam int CTL_POST_HI = 6;

  // Interrupt flag and enable position.
  localparam int IRQ_PERIOD_BIT = 1;

  // Prescaler terminal counts, one less than the ratio.
  localparam logic [3:0] PRE_TERM_1  = 4'h0;
  localparam logic [3:0] PRE_TERM_4  = 4'h3;
  localparam logic [3:0] PRE_TERM_16 = 4'hf;

  // Default divider from core clock to instruction clock.
  localparam int QUARTER_DIV = 4;

endpackage : pmt_pkg

`default_nettype wire

// ---- tb.sv ----
/*
  Self-checking bench for the period match timer: register access over
  Avalon-MM, prescaler and postscaler ratios, interrupt and time base.
  Assumes the design answers every request after a short wait.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pmt_pkg::*;

  // Short instruction tick keeps the run brief; expectations scale with it.
  localparam int Q = 2;
  localparam logic [9:0] A_FLG = {IDX_IRQ_FLAGS, 2'b00};
  localparam logic [9:0] A_CNT = {IDX_COUNTER, 2'b00};
  localparam logic [9:0] A_CTL = {IDX_CONTROL, 2'b00};
  localparam logic [9:0] A_ENA = {IDX_IRQ_ENABLES, 2'b00};
  localparam logic [9:0] A_LIM = {IDX_LIMIT, 2'b00};

  logic        mclk, reset, read, write, waitrequest, irq;
  logic        sspMatchPulse, pwmMatchPulse;
  logic [9:0]  address;
  logic [31:0] writedata, readdata, q;
  logic [3:0]  byteenable;
  logic [7:0]  pwmCount, v;
  int          errors, nChecks, n;

  pmt_period_match_timer8 #(.QDIV(Q)) pmt_period_match_timer8_inst (
    .mclk(mclk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .sspMatchPulse(sspMatchPulse), .pwmCount(pwmCount),
    .pwmMatchPulse(pwmMatchPulse));

  // Free-running core clock.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic wrap_up;
    if (errors == 0 && nChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The request stands until waitrequest is seen low at a rising edge;
  // read data is taken at that same edge, before the design updates it.
  task automatic bus(input logic isWr, input logic [9:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    @(posedge mclk);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    read <= !isWr;
    write <= isWr;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr

  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(q, {24'h0, e});
  endtask : rdc

  // Cycles between two match pulses, and the highest count in between.
  task automatic period(input int exp, input logic [7:0] lim);
    logic [7:0] top;
    top = 8'h00;
    n = 0;
    do @(negedge mclk); while (sspMatchPulse !== 1'b1);
    chk(pwmMatchPulse, 1'b1);
    chk(pwmCount, 8'h00);
    do begin
      @(negedge mclk);
      n++;
      if (pwmCount > top) top = pwmCount;
      chk(pwmMatchPulse, 32'(n == exp));
    end while (sspMatchPulse !== 1'b1);
    chk(n, exp);
    chk(top, lim);
  endtask : period

  // A hang counts as a mismatch and ends the run the normal way.
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    wrap_up();
  end

  // Main sequence of register calls and timed observations.
  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    byteenable = '0;
    errors = 0;
    nChecks = 0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    rdc(A_FLG, 8'h00);
    rdc(A_CNT, 8'h00);
    rdc(A_CTL, 8'h00);
    rdc(A_ENA, 8'h00);
    rdc(A_LIM, 8'hff);
    wr(A_CTL, 8'hfb);
    rdc(A_CTL, 8'h7b);
    wr(10'h3fc, 8'h55);
    rdc(10'h3fc, 8'h00);
    bus(1'b1, A_LIM, 8'h12, 4'h0);
    rdc(A_LIM, 8'hff);
    // Running counter survives control writes and freezes when off.
    wr(A_CNT, 8'h37);
    wr(A_CTL, 8'h04);
    repeat (20) @(posedge mclk);
    wr(A_CTL, 8'h00);
    bus(1'b0, A_CNT, 8'h00, 4'h1);
    v = q[7:0];
    chk(v > 8'h37, 1'b1);
    repeat (20) @(posedge mclk);
    rdc(A_CNT, v);
    // A counter write restarts the 1:16 prescaler from zero.
    wr(A_CTL, 8'h06);
    wr(A_CNT, 8'h05);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (pwmCount === 8'h05 && n < 200);
    chk(n >= 15 * Q + 2 && n <= 16 * Q + 1, 1'b1);
    // Every prescale code with a short period.
    wr(A_LIM, 8'h02);
    for (int p = 0; p < 4; p++) begin
      wr(A_CTL, 8'(4 + p));
      period(3 * Q * (p == 0 ? 1 : (p == 1 ? 4 : 16)), 8'h02);
    end
    // Postscaler boundaries: flag on every N+1th match.
    wr(A_LIM, 8'h01);
    wr(A_ENA, 8'h02);
    rdc(A_ENA, 8'h02);
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'h00 : ((k == 1) ? 8'h03 : 8'h0f);
      wr(A_CTL, 8'(v << 3));
      wr(A_FLG, 8'h02);
      wr(A_CTL, 8'((v << 3) | 8'h04));
      n = 0;
      do begin
        @(negedge mclk);
        if (sspMatchPulse === 1'b1) n++;
      end while (irq !== 1'b1);
      chk(n, v + 1);
    end
    // Sticky flag, masking and write-one-to-clear; irq is looked at on
    // the falling edge, once the written mask or flag has settled.
    wr(A_CTL, 8'h00);
    wr(A_ENA, 8'h00);
    @(negedge mclk);
    chk(irq, 1'b0);
    rdc(A_FLG, 8'h02);
    wr(A_ENA, 8'h02);
    @(negedge mclk);
    chk(irq, 1'b1);
    wr(A_FLG, 8'h02);
    rdc(A_FLG, 8'h00);
    @(negedge mclk);
    chk(irq, 1'b0);
    // A reset in mid-run must put every register back to its reset value.
    wr(A_LIM, 8'h33);
    wr(A_CNT, 8'h30);
    wr(A_CTL, 8'h04);
    repeat (20) @(negedge mclk);
    chk(irq, 1'b1);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk(irq, 1'b0);
    chk(pwmCount, 8'h00);
    rdc(A_LIM, 8'hff);
    rdc(A_CNT, 8'h00);
    rdc(A_CTL, 8'h00);
    rdc(A_ENA, 8'h00);
    rdc(A_FLG, 8'h00);
    wrap_up();
  end

endmodule : tb

`default_nettype wire
